// ==== stps_pkg.sv ====
package stps_pkg;

	// clock and timing
	localparam int CLK_HZ         = 100_000_000;
	localparam int CYC_PER_MS     = CLK_HZ / 1000;
	localparam int LAMP_MS        = 1000;
	localparam int SEG_MS         = 500;
	localparam int TIMEOUT_MS     = 12000;
	localparam int FLASH_HALF_MS  = 250;
	localparam int DEBOUNCE_MS    = 10;
	localparam int LAMP_CYCLES    = LAMP_MS * CYC_PER_MS;
	localparam int SEG_CYCLES     = SEG_MS * CYC_PER_MS;
	localparam int TIMEOUT_CYCLES = TIMEOUT_MS * CYC_PER_MS;
	localparam int FLASH_CYCLES   = FLASH_HALF_MS * CYC_PER_MS;
	localparam int DB_CYCLES      = DEBOUNCE_MS * CYC_PER_MS;
	localparam int CNT_W          = 32;

	// result storage
	localparam int REC_MAX = 8;
	localparam int ASM_MAX = 3;

	// display symbol codes: 0x00..0x0f are hex digits
	localparam logic [4:0] SYM_EIGHT = 5'h08;
	localparam logic [4:0] SYM_A     = 5'h0A;
	localparam logic [4:0] SYM_D     = 5'h0D;
	localparam logic [4:0] SYM_F     = 5'h0F;
	localparam logic [4:0] SYM_P     = 5'h10;
	localparam logic [4:0] SYM_U     = 5'h11;
	localparam logic [4:0] SYM_R     = 5'h12;
	localparam logic [4:0] SYM_BLANK = 5'h1F;

	// unit numbers on the display
	localparam logic [1:0] UNIT_DRIVE = 2'h0;
	localparam logic [1:0] UNIT_CTRL  = 2'h2;
	localparam logic [1:0] UNIT_LAST  = 2'h2;

	typedef enum logic [11:0] {
		S_LAMP      = 12'h001,
		S_RUN       = 12'h002,
		S_HOUSEKEEP = 12'h004,
		S_IDLE      = 12'h008,
		S_CTRL_FAIL = 12'h010,
		S_ST_REQ    = 12'h020,
		S_ST_GRANT  = 12'h040,
		S_SEG       = 12'h080,
		S_DENIED    = 12'h100,
		S_RES_REQ   = 12'h200,
		S_RES_HOLD  = 12'h400,
		S_SEQ       = 12'h800
	} stps_state_t;

	typedef enum logic [2:0] {
		K_UNIT = 3'h1,
		K_ASM  = 3'h2,
		K_SUB  = 3'h4
	} stps_kind_t;

endpackage : stps_pkg

// ==== stps_debounce.sv ====
`timescale 1ns/10ps
module stps_debounce
	import stps_pkg::*;
#(
	parameter int DB_CNT = DB_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic pin,
	output logic      level,
	output logic      press,
	output logic      release_evt
);
	logic             sync_a;
	logic             sync_b;
	logic [CNT_W-1:0] cnt;
	wire              differs = sync_b != level;
	wire              settled = differs && (cnt >= CNT_W'(DB_CNT - 1));

	always_ff @(posedge clk) begin
		if (rst) begin
			sync_a      <= 1'b0;
			sync_b      <= 1'b0;
			cnt         <= '0;
			level       <= 1'b0;
			press       <= 1'b0;
			release_evt <= 1'b0;
		end else begin
			sync_a      <= pin;
			sync_b      <= sync_a;
			cnt         <= (differs && !settled) ? cnt + 1'b1 : '0;
			level       <= settled ? sync_b : level;
			press       <= settled && sync_b;
			release_evt <= settled && !sync_b;
		end
	end
endmodule : stps_debounce

// ==== stps_flash.sv ====
`timescale 1ns/10ps
module stps_flash
	import stps_pkg::*;
#(
	parameter int HALF_CNT = FLASH_CYCLES
) (
	input  wire logic clk,
	input  wire logic rst,
	output logic      flash
);
	logic [CNT_W-1:0] cnt;
	wire              wrap = cnt >= CNT_W'(HALF_CNT - 1);

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt   <= '0;
			flash <= 1'b0;
		end else begin
			cnt   <= wrap ? '0 : cnt + 1'b1;
			flash <= wrap ? !flash : flash;
		end
	end
endmodule : stps_flash

// ==== stps_sequencer.sv ====
`timescale 1ns/10ps
module stps_sequencer
	import stps_pkg::*;
#(
	parameter int LAMP_CNT    = LAMP_CYCLES,
	parameter int SEG_CNT     = SEG_CYCLES,
	parameter int TIMEOUT_CNT = TIMEOUT_CYCLES,
	parameter int FLASH_CNT   = FLASH_CYCLES,
	parameter int DB_CNT      = DB_CYCLES,
	parameter int RECS        = REC_MAX,
	parameter int ASMS        = ASM_MAX
) (
	input  wire logic              clk,
	input  wire logic              rst,
	input  wire logic              selftest_btn,
	input  wire logic              results_btn,
	input  wire logic              host_grant,
	input  wire logic              host_deny,
	input  wire logic              host_selftest_cmd,
	input  wire logic              drive_active,
	input  wire logic [2:0]        bus_address,
	input  wire logic              st_done,
	input  wire logic              st_pass,
	input  wire logic              st_ctrl_fail,
	input  wire logic              hk_done,
	input  wire logic              rec_wr,
	input  wire logic [1:0]        rec_unit_in,
	input  wire logic [1:0]        rec_asm_n_in,
	input  wire logic [ASMS*4-1:0] rec_asm_in,
	input  wire logic [7:0]        rec_sub_in,
	output logic                   st_start,
	output logic                   st_reduced,
	output logic                   release_req,
	output logic                   host_cmd_enable,
	output logic                   lamp_red,
	output logic                   lamp_green,
	output logic [4:0]             disp_hi,
	output logic [4:0]             disp_lo
);
	localparam int RW = $clog2(RECS);
	localparam logic [RW:0] SENT = (RW+1)'(RECS);

	stps_state_t      state, next_state;
	stps_kind_t       seq_kind, next_kind;
	logic [CNT_W-1:0] timer;
	logic             passed, seq_on, seq_end;
	logic [1:0]       seq_unit, next_unit;
	logic [RW:0]      seq_ptr, next_ptr;
	logic [1:0]       seq_ai, next_ai;
	logic [RW:0]      rec_cnt;
	logic [RW:0]      hit_first, hit_more;
	logic [1:0]       rec_unit  [RECS];
	logic [1:0]       rec_asm_n [RECS];
	logic [3:0]       rec_asm   [RECS][ASMS];
	logic [7:0]       rec_sub   [RECS];
	logic [4:0]       next_hi, next_lo;
	logic             st_lvl, st_press, st_rel;
	logic             rs_lvl, rs_press, rs_rel;
	logic             flash;

	stps_debounce #(.DB_CNT(DB_CNT)) u_db_st (
		.clk         (clk),
		.rst         (rst),
		.pin         (selftest_btn),
		.level       (st_lvl),
		.press       (st_press),
		.release_evt (st_rel)
	);
	stps_debounce #(.DB_CNT(DB_CNT)) u_db_rs (
		.clk         (clk),
		.rst         (rst),
		.pin         (results_btn),
		.level       (rs_lvl),
		.press       (rs_press),
		.release_evt (rs_rel)
	);
	stps_flash #(.HALF_CNT(FLASH_CNT)) u_flash (
		.clk   (clk),
		.rst   (rst),
		.flash (flash)
	);

	// first stored record of unit u at or after index from, else SENT
	function automatic logic [RW:0] next_of(input logic [1:0] u, input logic [RW:0] from);
		logic [RW:0] hit;
		hit = SENT;
		for (int i = RECS - 1; i >= 0; i--) begin
			if ((RW+1)'(i) >= from && (RW+1)'(i) < rec_cnt && rec_unit[i] == u) begin
				hit = (RW+1)'(i);
			end
		end
		return hit;
	endfunction : next_of

	wire [RW-1:0] cur     = seq_ptr[RW-1:0];
	wire [1:0] start_unit = (state == S_CTRL_FAIL) ? UNIT_CTRL : UNIT_DRIVE;
	wire timer_lamp       = timer >= CNT_W'(LAMP_CNT - 1);
	wire timer_seg        = timer >= CNT_W'(SEG_CNT - 1);
	wire timer_out        = timer >= CNT_W'(TIMEOUT_CNT - 1);
	wire run_end          = st_done || timer_out;
	wire run_pass         = st_done && st_pass && !st_ctrl_fail;
	wire both_up          = !st_lvl && !rs_lvl;
	wire step             = rs_press && (state == S_SEQ || state == S_CTRL_FAIL);
	wire [4:0] code_hi    = passed ? SYM_P : SYM_F;
	wire [4:0] code_lo    = {2'h0, bus_address};

	// next item of the results walk
	always_comb begin
		hit_first = next_of(seq_unit, '0);
		hit_more  = next_of(seq_unit, seq_ptr + 1'b1);
		next_kind = seq_kind;
		next_unit = seq_unit;
		next_ptr  = seq_ptr;
		next_ai   = seq_ai;
		seq_end   = 1'b0;
		case (seq_kind)
			K_UNIT: begin
				if (hit_first != SENT) begin
					next_ptr  = hit_first;
					next_ai   = 2'h0;
					next_kind = (rec_asm_n[hit_first[RW-1:0]] != 2'h0) ? K_ASM : K_SUB;
				end else if (seq_unit == UNIT_LAST) begin
					seq_end = 1'b1;
				end else begin
					next_unit = seq_unit + 1'b1;
				end
			end
			K_ASM: begin
				if (seq_ai + 1'b1 < rec_asm_n[cur]) begin
					next_ai = seq_ai + 1'b1;
				end else begin
					next_kind = K_SUB;
				end
			end
			K_SUB: begin
				if (hit_more != SENT) begin
					next_ptr  = hit_more;
					next_ai   = 2'h0;
					next_kind = (rec_asm_n[hit_more[RW-1:0]] != 2'h0) ? K_ASM : K_SUB;
				end else if (seq_unit == UNIT_LAST) begin
					seq_end = 1'b1;
				end else begin
					next_unit = seq_unit + 1'b1;
					next_kind = K_UNIT;
				end
			end
			default: begin
				seq_end = 1'b1;
			end
		endcase
	end

	// state transitions
	always_comb begin
		next_state = state;
		case (state)
			S_LAMP:      if (timer_lamp) next_state = S_RUN;
			S_RUN: begin
				if (st_done && st_ctrl_fail) next_state = S_CTRL_FAIL;
				else if (run_pass) next_state = S_IDLE;
				else if (run_end) next_state = S_HOUSEKEEP;
			end
			S_HOUSEKEEP: if (hk_done) next_state = S_IDLE;
			S_IDLE: begin
				if (host_selftest_cmd) next_state = S_RUN;
				else if (st_press) next_state = S_ST_REQ;
				else if (rs_press) next_state = S_RES_REQ;
			end
			S_ST_REQ: begin
				if (host_grant) next_state = S_ST_GRANT;
				else if (host_deny) next_state = S_DENIED;
				else if (!st_lvl) next_state = S_IDLE;
			end
			S_ST_GRANT:  if (st_rel) next_state = S_SEG;
			S_SEG:       if (timer_seg) next_state = S_RUN;
			S_DENIED:    if (both_up) next_state = S_IDLE;
			S_RES_REQ: begin
				if (host_grant) next_state = S_RES_HOLD;
				else if (host_deny) next_state = S_DENIED;
				else if (!rs_lvl) next_state = S_IDLE;
			end
			S_RES_HOLD:  if (rs_rel) next_state = S_SEQ;
			S_SEQ:       if (step && seq_on && seq_end) next_state = S_IDLE;
			S_CTRL_FAIL: next_state = S_CTRL_FAIL;
			default:     next_state = S_LAMP;
		endcase
	end

	// display selection
	always_comb begin
		next_hi = code_hi;
		next_lo = code_lo;
		case (state)
			S_LAMP, S_SEG: begin
				next_hi = SYM_EIGHT;
				next_lo = SYM_EIGHT;
			end
			S_RUN, S_ST_GRANT, S_RES_HOLD: begin
				next_hi = SYM_BLANK;
				next_lo = SYM_BLANK;
			end
			S_DENIED: begin
				next_hi = SYM_R;
				next_lo = SYM_D;
			end
			S_SEQ, S_CTRL_FAIL: begin
				if (seq_on) begin
					case (seq_kind)
						K_UNIT: begin
							next_hi = SYM_U;
							next_lo = {3'h0, seq_unit};
						end
						K_ASM: begin
							next_hi = SYM_A;
							next_lo = {1'b0, rec_asm[cur][seq_ai]};
						end
						default: begin
							next_hi = {1'b0, rec_sub[cur][7:4]};
							next_lo = {1'b0, rec_sub[cur][3:0]};
						end
					endcase
				end
			end
			default: next_hi = code_hi;
		endcase
	end

	// lamps
	wire in_run    = state == S_RUN || state == S_SEG;
	wire result_st = !(state == S_LAMP || in_run || state == S_HOUSEKEEP
	                   || state == S_CTRL_FAIL);
	assign lamp_red   = state == S_LAMP || state == S_HOUSEKEEP || state == S_CTRL_FAIL
	                    || (result_st && !passed);
	assign lamp_green = state == S_LAMP || state == S_CTRL_FAIL
	                    || ((in_run || state == S_HOUSEKEEP) && flash)
	                    || (result_st && passed && (!drive_active || flash))
	                    || (result_st && !passed && drive_active && flash);
	assign release_req     = state == S_ST_REQ || state == S_ST_GRANT || state == S_RES_REQ
	                         || state == S_RES_HOLD || state == S_SEQ;
	assign host_cmd_enable = state == S_IDLE;

	always_ff @(posedge clk) begin
		if (rst) begin
			state      <= S_LAMP;
			timer      <= '0;
			passed     <= 1'b0;
			st_start   <= 1'b0;
			st_reduced <= 1'b0;
			disp_hi    <= SYM_EIGHT;
			disp_lo    <= SYM_EIGHT;
		end else begin
			state    <= next_state;
			timer    <= (next_state != state) ? '0 : timer + 1'b1;
			disp_hi  <= next_hi;
			disp_lo  <= next_lo;
			st_start <= next_state == S_RUN && state != S_RUN;
			if (next_state == S_RUN && state != S_RUN) begin
				st_reduced <= state != S_LAMP;
			end
			if (state == S_RUN && run_end) begin
				passed <= run_pass;
			end
		end
	end

	// walk pointer
	always_ff @(posedge clk) begin
		if (rst) begin
			seq_on   <= 1'b0;
			seq_kind <= K_UNIT;
			seq_unit <= UNIT_DRIVE;
			seq_ptr  <= '0;
			seq_ai   <= 2'h0;
		end else if (step && !seq_on) begin
			seq_on   <= 1'b1;
			seq_kind <= K_UNIT;
			seq_unit <= start_unit;
			seq_ptr  <= '0;
			seq_ai   <= 2'h0;
		end else if (step) begin
			seq_on   <= !seq_end;
			seq_kind <= next_kind;
			seq_unit <= next_unit;
			seq_ptr  <= next_ptr;
			seq_ai   <= next_ai;
		end else if (state != S_SEQ && state != S_CTRL_FAIL) begin
			seq_on <= 1'b0;
		end
	end

	// result records, cleared at each run start
	always_ff @(posedge clk) begin
		if (rst) begin
			rec_cnt <= '0;
		end else if (st_start) begin
			rec_cnt <= '0;
		end else if (rec_wr && rec_cnt < SENT) begin
			rec_cnt <= rec_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rec_wr && !st_start && rec_cnt < SENT) begin
			rec_unit[rec_cnt[RW-1:0]]  <= rec_unit_in;
			rec_asm_n[rec_cnt[RW-1:0]] <= rec_asm_n_in;
			rec_sub[rec_cnt[RW-1:0]]   <= rec_sub_in;
			for (int k = 0; k < ASMS; k++) begin
				rec_asm[rec_cnt[RW-1:0]][k] <= rec_asm_in[k*4 +: 4];
			end
		end
	end
endmodule : stps_sequencer

// ==== stps_sequencer_monitor.sv ====
`timescale 1ns/10ps
module stps_sequencer_monitor
	import stps_pkg::*;
#(
	parameter int LAMP_CNT = LAMP_CYCLES
) (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic       host_grant,
	input wire logic       host_deny,
	input wire logic       host_selftest_cmd,
	input wire logic       drive_active,
	input wire logic       st_done,
	input wire logic       st_pass,
	input wire logic       st_ctrl_fail,
	input wire logic       st_start,
	input wire logic       st_reduced,
	input wire logic       release_req,
	input wire logic       host_cmd_enable,
	input wire logic       lamp_red,
	input wire logic       lamp_green,
	input wire logic [4:0] disp_hi,
	input wire logic [4:0] disp_lo
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	int since;
	// cycles since reset release, saturating
	always_ff @(posedge clk)
		if (rst)
			since <= 0;
		else if (since < LAMP_CNT)
			since <= since + 1;
	lamp_check_a: assert property (since < LAMP_CNT - 1 |-> lamp_red && lamp_green)
		else $error("lamp check not lit");
	start_pulse_a: assert property (st_start |=> !st_start)
		else $error("start pulse too long");
	idle_release_a: assert property (host_cmd_enable |-> !release_req)
		else $error("release held while online");
	host_start_a: assert property (host_cmd_enable && host_selftest_cmd
		|=> st_start && st_reduced) else $error("host run did not start");
	host_blank_a: assert property (host_cmd_enable && host_selftest_cmd
		|=> ##1 (disp_hi == SYM_BLANK && disp_lo == SYM_BLANK) [*4])
		else $error("display not blank");
	deny_code_a: assert property (release_req && host_deny && !host_grant
		|-> ##2 disp_hi == SYM_R && disp_lo == SYM_D) else $error("deny code missing");
	ctrl_lock_a: assert property (st_done && st_ctrl_fail && !lamp_red
		|=> (lamp_red && lamp_green && !host_cmd_enable) [*8]) else $error("lock lamps wrong");
	pass_green_a: assert property (st_done && st_pass && !st_ctrl_fail
		&& !lamp_red && !drive_active |=> lamp_green && !lamp_red && host_cmd_enable)
		else $error("pass lamp wrong");
endmodule : stps_sequencer_monitor
bind stps_sequencer stps_sequencer_monitor #(.LAMP_CNT(LAMP_CNT)) mon (.*);

// ==== stps_far_model.sv ====
`timescale 1ns/10ps
module stps_far_model (
	input  wire logic   clk,
	input  wire logic   rst,
	input  wire logic   release_req,
	input  wire logic   st_start,
	input  wire logic   cfg_deny,
	input  wire logic   cfg_pass,
	input  wire logic   cfg_ctrl,
	input  wire logic   cfg_silent,
	output logic        host_grant,
	output logic        host_deny,
	output logic        st_done,
	output logic        st_pass,
	output logic        st_ctrl_fail,
	output logic        hk_done,
	output logic        rec_wr,
	output logic [1:0]  rec_unit_in,
	output logic [1:0]  rec_asm_n_in,
	output logic [11:0] rec_asm_in,
	output logic [7:0]  rec_sub_in
);
	initial begin
		{host_grant, host_deny} = 2'h0;
		forever begin
			@(negedge clk);
			if (release_req && !rst) begin
				repeat (3) @(negedge clk);
				host_grant = !cfg_deny;
				host_deny = cfg_deny;
				@(negedge clk);
				{host_grant, host_deny} = 2'h0;
				while (release_req) @(negedge clk);
			end
		end
	end
	initial begin
		{st_done, hk_done, rec_wr, st_pass, st_ctrl_fail} = 5'h03;
		{rec_unit_in, rec_asm_n_in, rec_asm_in, rec_sub_in} = 24'hff_ffff;
		forever begin
			@(negedge clk);
			if (st_start && !rst) begin
				repeat (3) @(negedge clk);
				if (!cfg_pass) begin
					rec_wr = 1'b1;
					rec_unit_in = cfg_ctrl ? 2'h2 : 2'h0;
					rec_asm_n_in = 2'h2;
					rec_asm_in = 12'h013;
					rec_sub_in = 8'h2c;
				end
				@(negedge clk);
				rec_wr = 1'b0;
				{rec_unit_in, rec_asm_n_in, rec_asm_in, rec_sub_in} = 24'hff_ffff;
				// silent run never reports, so the design must time out
				repeat (cfg_silent ? 600 : 60) @(negedge clk);
				{st_done, st_pass, st_ctrl_fail} = {!cfg_silent, cfg_pass, cfg_ctrl};
				@(negedge clk);
				{st_done, st_pass, st_ctrl_fail} = {1'b0, !cfg_pass, !cfg_ctrl};
				if (!cfg_pass && !cfg_ctrl) begin
					repeat (60) @(negedge clk);
					hk_done = 1'b1;
					@(negedge clk);
					hk_done = 1'b0;
				end
			end
		end
	end
endmodule : stps_far_model

// ==== testbench.sv ====
`timescale 1ns/10ps
module testbench
	import stps_pkg::*;
	;
	logic        clk, rst, selftest_btn, results_btn, host_selftest_cmd, drive_active;
	logic        host_grant, host_deny, st_done, st_pass, st_ctrl_fail, hk_done, rec_wr;
	logic        st_start, st_reduced, release_req, host_cmd_enable, lamp_red, lamp_green;
	logic        cfg_deny, cfg_pass, cfg_ctrl, cfg_silent, seg_seen;
	logic [1:0]  rec_unit_in, rec_asm_n_in;
	logic [11:0] rec_asm_in;
	logic [7:0]  rec_sub_in;
	logic [4:0]  disp_hi, disp_lo;
	int          num_errors, num_checks;
	localparam logic [2:0] ADDR = 3'h5;
	localparam logic [9:0] NORM [7] = '{10'h220, 10'h143, 10'h141, 10'h04c, 10'h221,
		10'h222, 10'h1e5};
	localparam logic [9:0] LOCK [6] = '{10'h222, 10'h143, 10'h141, 10'h04c, 10'h1e5, 10'h222};

	stps_sequencer #(.LAMP_CNT(20), .SEG_CNT(10), .TIMEOUT_CNT(500), .FLASH_CNT(4), .DB_CNT(3))
		dut (.bus_address(ADDR), .*);
	stps_far_model far (.*);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(negedge clk)
		if ({disp_hi, disp_lo} === {SYM_EIGHT, SYM_EIGHT})
			seg_seen = 1'b1;

	task automatic chk(input logic [9:0] got, input logic [9:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wdisp(input logic [4:0] h, input logic [4:0] l);
		int n;
		n = 0;
		while ({disp_hi, disp_lo} !== {h, l} && n < 900) begin
			@(negedge clk);
			n++;
		end
		chk({disp_hi, disp_lo}, {h, l});
	endtask : wdisp
	task automatic wsig(input int k, output int n);
		n = 0;
		while (!(k == 0 ? st_start : k == 1 ? lamp_red : host_cmd_enable) && n < 900) begin
			@(negedge clk);
			n++;
		end
		chk(10'(n < 900), 10'h001);
	endtask : wsig
	task automatic push(input bit r, input logic v);
		if (r)
			results_btn = v;
		else
			selftest_btn = v;
		repeat (10) @(negedge clk);
	endtask : push
	task automatic step(input logic [9:0] e);
		push(1, 1'b1);
		push(1, 1'b0);
		chk({disp_hi, disp_lo}, e);
	endtask : step
	task automatic cmd();
		host_selftest_cmd = 1'b1;
		@(negedge clk);
		host_selftest_cmd = 1'b0;
	endtask : cmd
	task automatic flashes(output int t);
		logic p;
		t = 0;
		repeat (20) begin
			p = lamp_green;
			@(negedge clk);
			t += int'(lamp_green !== p);
		end
	endtask : flashes

	task automatic t_power();
		int n;
		chk({8'h00, lamp_red, lamp_green}, 10'h003);
		chk({disp_hi, disp_lo}, {SYM_EIGHT, SYM_EIGHT});
		wsig(0, n);
		chk(10'(n >= 19 && n <= 23), 10'h001);
		chk(10'(st_reduced), 10'h000);
		flashes(n);
		chk(10'(n), 10'h005);
		wdisp(SYM_P, 5'(ADDR));
		chk({8'h00, lamp_red, lamp_green}, 10'h001);
		$display("t_power done");
	endtask : t_power
	task automatic t_host();
		int n;
		seg_seen = 1'b0;
		cfg_pass = 1'b0;
		cmd();
		chk({8'h00, st_start, st_reduced}, 10'h003);
		wsig(1, n);
		flashes(n);
		chk({lamp_red, 9'(n)}, 10'h205);
		push(1, 1'b1);
		chk(10'(release_req), 10'h000);
		push(1, 1'b0);
		wsig(2, n);
		chk({8'h00, lamp_red, lamp_green}, 10'h002);
		drive_active = 1'b1;
		@(negedge clk);
		flashes(n);
		chk(10'(n), 10'h005);
		drive_active = 1'b0;
		chk({disp_hi, disp_lo}, {SYM_F, 5'(ADDR)});
		chk(10'(seg_seen), 10'h000);
		$display("t_host done");
	endtask : t_host
	task automatic t_results();
		push(1, 1'b1);
		wdisp(SYM_BLANK, SYM_BLANK);
		chk(10'(release_req), 10'h001);
		push(1, 1'b0);
		wdisp(SYM_F, 5'(ADDR));
		for (int i = 0; i < 7; i++) begin
			step(NORM[i]);
			chk(10'(release_req), 10'(i < 6));
		end
		$display("t_results done");
	endtask : t_results
	task automatic t_deny();
		cfg_deny = 1'b1;
		push(0, 1'b1);
		wdisp(SYM_R, SYM_D);
		push(0, 1'b0);
		wdisp(SYM_F, 5'(ADDR));
		chk(10'(release_req), 10'h000);
		cfg_deny = 1'b0;
		$display("t_deny done");
	endtask : t_deny
	task automatic t_button();
		int n;
		cfg_pass = 1'b1;
		push(0, 1'b1);
		wdisp(SYM_BLANK, SYM_BLANK);
		push(0, 1'b0);
		wdisp(SYM_EIGHT, SYM_EIGHT);
		wsig(0, n);
		chk(10'(st_reduced), 10'h001);
		wdisp(SYM_BLANK, SYM_BLANK);
		wdisp(SYM_P, 5'(ADDR));
		$display("t_button done");
	endtask : t_button
	task automatic t_timeout();
		int n;
		{cfg_pass, cfg_silent} = 2'h1;
		cmd();
		wsig(1, n);
		chk(10'(n >= 495 && n <= 505), 10'h001);
		wsig(2, n);
		chk({disp_hi, disp_lo}, {SYM_F, 5'(ADDR)});
		cfg_silent = 1'b0;
		$display("t_timeout done");
	endtask : t_timeout
	task automatic t_lock();
		int n;
		cfg_ctrl = 1'b1;
		cmd();
		wsig(1, n);
		chk({7'h00, lamp_red, lamp_green, host_cmd_enable}, 10'h006);
		cmd();
		chk(10'(st_start), 10'h000);
		for (int i = 0; i < 6; i++)
			step(LOCK[i]);
		$display("t_lock done");
	endtask : t_lock
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop

	initial begin
		{rst, selftest_btn, results_btn, host_selftest_cmd, drive_active} = 5'h10;
		{cfg_deny, cfg_pass, cfg_ctrl, cfg_silent, seg_seen} = 5'h08;
		num_errors = 0;
		num_checks = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		t_power();
		t_host();
		t_results();
		t_deny();
		t_button();
		t_timeout();
		t_lock();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(negedge clk);
		num_errors++;
		report_and_stop();
	end
endmodule : testbench
